/* File: common/uef_regs.svh */
// Constants for the upstream error forwarding block
`ifndef UEF_REGS_SVH
`define UEF_REGS_SVH
// ************************************************************
// Error source indices (bit positions in the per-error vectors)
// ************************************************************
`define UEF_ERR_DATA    2'd0
`define UEF_ERR_PERR    2'd1
`define UEF_ERR_ADDR    2'd2
`define UEF_ERR_ATTR    2'd3
`define UEF_NUM_ERR     4
// ************************************************************
// Pointer encodings and widths
// ************************************************************
`define UEF_PTR_W       3
`define UEF_PTR_NONE    3'h0
`define UEF_HDR_W       128
`define UEF_ALL_ONES    32'hFFFF_FFFF
`define UEF_STAT_RST    1'b0
`endif

/* File: common/uef_pkg.sv */
// Types shared by the upstream error forwarding block
package uef_pkg;
  // Completion status seen on the upstream link
  typedef enum logic [1:0] {
    UEF_CPL_SC = 2'h0,
    UEF_CPL_UR = 2'h1,
    UEF_CPL_CA = 2'h2
  } uef_cpl_t;

  // Kind of delayed transaction that got the completion
  typedef enum logic [1:0] {
    UEF_DT_MRD = 2'h0,
    UEF_DT_IORD = 2'h1,
    UEF_DT_IOWR = 2'h2
  } uef_dt_t;

  // One completion event toward the secondary bus
  typedef struct packed {
    logic       valid;
    uef_dt_t    kind;
    uef_cpl_t   status;
  } uef_cpl_evt_t;

  // Answer to the originating master of a delayed transaction
  typedef struct packed {
    logic        valid;
    logic        target_abort;
    logic        normal;
    logic        force_ones;
    logic [31:0] data;
  } uef_dt_resp_t;

  // Error message request toward the upstream link
  typedef struct packed {
    logic valid;
    logic fatal;
  } uef_msg_t;
endpackage : uef_pkg

/* File: design/uef_cpl_map.sv */
// Maps delayed-transaction completion status to the PCI answer
`timescale 1ns/100ps
module uef_cpl_map (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Mode
  input  wire logic                  ir_master_abort_mode,
  // Completion event in
  input  wire uef_pkg::uef_cpl_evt_t cpl_evt,
  // Registered answer out
  output uef_pkg::uef_dt_resp_t      dt_resp
);
  `include "uef_regs.svh"
  // ************************************************************
  // Decode
  // ************************************************************
  // Completer abort always aborts; UR only in immediate mode
  wire is_ur = cpl_evt.status == uef_pkg::UEF_CPL_UR;
  wire is_ca = cpl_evt.status == uef_pkg::UEF_CPL_CA;
  wire is_rd = cpl_evt.kind != uef_pkg::UEF_DT_IOWR;
  wire abort = is_ca || (is_ur && ir_master_abort_mode); // [R02] [R03] [R04]
  wire ones  = is_ur && !ir_master_abort_mode && is_rd;  // [R02]
  uef_pkg::uef_dt_resp_t resp_nxt;
  assign resp_nxt.valid        = cpl_evt.valid;
  assign resp_nxt.target_abort = cpl_evt.valid && abort;
  assign resp_nxt.normal       = cpl_evt.valid && !abort; // [R03]
  assign resp_nxt.force_ones   = cpl_evt.valid && ones;
  assign resp_nxt.data         = ones ? `UEF_ALL_ONES : 32'h0000_0000;

  // Registered so the top sees one clean cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dt_resp <= '0;
    end else begin
      dt_resp <= resp_nxt;
    end
  end
endmodule : uef_cpl_map

/* File: design/uef_top.sv */
// Upstream (PCI to link) error forwarding for the bridge
// What this block does
// [R01] Bad-parity writes go upstream poisoned
// [R02] UR on read: abort or all-ones
// [R03] UR on I/O write: abort or normal
// [R04] Completer abort always gives target abort
// [R05] Write data parity error sets detected parity
// [R06] Non-posted bad write, response on: drop, PERR
// [R07] Non-posted bad write, response off: poison
// [R08] Write data parity error sets data status
// [R09] Log header when unmasked and pointer empty
// [R10] Message by severity when unmasked and enabled
// [R11] Message with system enable sets signaled error
// [R12] Set fatal or nonfatal detected by severity
// [R13] Posted bad write, response on: PERR, master
// [R14] PERR on read completion: continue, set status
// [R15] Poisoned completion PERR: same, no message
// [R16] Address error, response on: abort, discard
// [R17] Address/attribute error sets detected parity
// [R18] Address error: status, log, message
// [R19] Attribute error behaves as address error when response is on
// [R20] Status bits stay set until software clears
`timescale 1ns/100ps
`include "uef_regs.svh"
module uef_top #(
  parameter int HDR_W = `UEF_HDR_W
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Configuration
  input  wire logic                  secondary_parity_response_enable,
  input  wire logic                  ir_master_abort_mode,
  input  wire logic                  system_error_enable,
  input  wire logic                  fatal_reporting_enable,
  input  wire logic                  nonfatal_reporting_enable,
  input  wire logic [3:0]            err_mask,
  input  wire logic [3:0]            err_severity,
  // Software clears, one bit per status flag
  input  wire logic [3:0]            unc_status_clr,
  input  wire logic                  detected_parity_error_clr,
  input  wire logic                  master_data_parity_error_clr,
  input  wire logic                  signaled_target_abort_clr,
  input  wire logic                  signaled_system_error_clr,
  input  wire logic                  fatal_error_detected_clr,
  input  wire logic                  nonfatal_error_detected_clr,
  input  wire logic                  first_error_pointer_clr,
  // Secondary bus events
  input  wire logic                  wr_valid,
  input  wire logic                  wr_posted,
  input  wire logic                  wr_parity_err,
  input  wire logic                  addr_parity_err,
  input  wire logic                  attr_parity_err,
  input  wire logic                  rd_cpl_perr,
  input  wire logic                  rd_cpl_poisoned,
  input  wire logic [HDR_W-1:0]      evt_header,
  input  wire uef_pkg::uef_cpl_evt_t cpl_evt,
  // Forwarding decisions
  output logic                       fwd_valid,
  output logic                       fwd_poisoned,
  output logic                       wr_discard,
  output logic                       perr_assert,
  output logic                       addr_target_abort,
  output logic                       rd_cpl_continue,
  output uef_pkg::uef_dt_resp_t      dt_resp,
  output uef_pkg::uef_msg_t          msg_req,
  // Status
  output logic [3:0]                 unc_status_r,
  output logic                       detected_parity_error_r,
  output logic                       master_data_parity_error_r,
  output logic                       signaled_target_abort_r,
  output logic                       signaled_system_error_r,
  output logic                       fatal_error_detected_r,
  output logic                       nonfatal_error_detected_r,
  output logic [`UEF_PTR_W-1:0]      first_error_pointer_r,
  output logic [HDR_W-1:0]           header_log_r
);

  // ************************************************************
  // Event decode
  // ************************************************************
  // Address/attribute errors win over data checks on same cycle
  wire aa_err   = addr_parity_err || attr_parity_err;
  wire data_err = wr_valid && wr_parity_err && !aa_err;
  wire np_drop  = data_err && !wr_posted
                  && secondary_parity_response_enable;       // [R06]
  wire p_perr   = data_err && wr_posted
                  && secondary_parity_response_enable;       // [R13]
  // Attribute errors only count with parity response on
  wire attr_hit = attr_parity_err
                  && secondary_parity_response_enable;       // [R19]
  wire aa_abort = addr_parity_err
                  && secondary_parity_response_enable;       // [R16]

  logic [3:0] err_hit;
  assign err_hit[`UEF_ERR_DATA] = data_err;                  // [R08]
  assign err_hit[`UEF_ERR_PERR] = rd_cpl_perr;               // [R14]
  assign err_hit[`UEF_ERR_ADDR] = addr_parity_err;           // [R18]
  assign err_hit[`UEF_ERR_ATTR] = attr_hit;                  // [R19]

  // ************************************************************
  // Per-error reporting qualifiers
  // ************************************************************
  // A poisoned completion reports status but sends no message
  logic [3:0] err_live;
  logic [3:0] err_msg;
  logic [3:0] err_fatal;
  logic [3:0] err_nonfatal;
  genvar gi;
  generate
    for (gi = 0; gi < `UEF_NUM_ERR; gi++) begin : g_err
      assign err_live[gi] = err_hit[gi] && !err_mask[gi];
      assign err_fatal[gi] = err_hit[gi] && err_severity[gi];  // [R12]
      assign err_nonfatal[gi] = err_hit[gi] && !err_severity[gi];
      assign err_msg[gi] = err_live[gi]
        && !(gi == `UEF_ERR_PERR && rd_cpl_poisoned)          // [R15]
        && (system_error_enable
            || (err_severity[gi] ? fatal_reporting_enable
                                 : nonfatal_reporting_enable)); // [R10]
    end
  endgenerate

  wire any_msg   = |err_msg;
  wire msg_fatal = |(err_msg & err_severity);

  // ************************************************************
  // First error pointer and header log
  // ************************************************************
  // Lowest index wins when two errors land together
  logic [`UEF_PTR_W-1:0] ptr_pick;
  always_comb begin
    ptr_pick = `UEF_PTR_NONE;
    for (int i = `UEF_NUM_ERR - 1; i >= 0; i--) begin
      if (err_live[i]) begin
        ptr_pick = `UEF_PTR_W'(i + 1);
      end
    end
  end
  wire ptr_empty = first_error_pointer_r == `UEF_PTR_NONE;
  wire log_now   = ptr_empty && (|err_live);                  // [R09]
  wire [`UEF_PTR_W-1:0] ptr_nxt =
    log_now ? ptr_pick
            : (first_error_pointer_clr ? `UEF_PTR_NONE
                                       : first_error_pointer_r);

  // Pointer locks the log until software frees it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      first_error_pointer_r <= `UEF_PTR_NONE;
      header_log_r          <= '0;
    end else begin
      first_error_pointer_r <= ptr_nxt;                      // [R09]
      if (log_now) begin
        header_log_r <= evt_header;                          // [R18]
      end
    end
  end

  // ************************************************************
  // Sticky status; set beats a same-cycle clear
  // ************************************************************
  wire [3:0] unc_status_nxt = (unc_status_r & ~unc_status_clr)
                              | err_hit;                     // [R20]
  wire dpe_set = data_err || aa_err;                         // [R05] [R17]
  wire dpe_nxt = dpe_set
                 || (detected_parity_error_r
                     && !detected_parity_error_clr);
  wire mdp_nxt = p_perr
                 || (master_data_parity_error_r
                     && !master_data_parity_error_clr);      // [R13]
  wire sta_nxt = aa_abort || attr_hit || dt_resp.target_abort
                 || (signaled_target_abort_r
                     && !signaled_target_abort_clr);         // [R16]
  wire sse_set = any_msg && system_error_enable;             // [R11]
  wire sse_nxt = sse_set
                 || (signaled_system_error_r
                     && !signaled_system_error_clr);
  wire fed_nxt = (|err_fatal)
                 || (fatal_error_detected_r
                     && !fatal_error_detected_clr);          // [R12]
  wire ned_nxt = (|err_nonfatal)
                 || (nonfatal_error_detected_r
                     && !nonfatal_error_detected_clr);       // [R12]

  // Status registers, never cleared by good traffic
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      unc_status_r               <= '0;
      detected_parity_error_r    <= `UEF_STAT_RST;
      master_data_parity_error_r <= `UEF_STAT_RST;
      signaled_target_abort_r    <= `UEF_STAT_RST;
      signaled_system_error_r    <= `UEF_STAT_RST;
      fatal_error_detected_r     <= `UEF_STAT_RST;
      nonfatal_error_detected_r  <= `UEF_STAT_RST;
    end else begin
      unc_status_r               <= unc_status_nxt;          // [R20]
      detected_parity_error_r    <= dpe_nxt;
      master_data_parity_error_r <= mdp_nxt;
      signaled_target_abort_r    <= sta_nxt;
      signaled_system_error_r    <= sse_nxt;
      fatal_error_detected_r     <= fed_nxt;
      nonfatal_error_detected_r  <= ned_nxt;
    end
  end

  // ************************************************************
  // Forwarding decisions and message request
  // ************************************************************
  // Poison any bad write that is not dropped
  wire fwd_nxt    = wr_valid && !aa_err && !np_drop;         // [R06]
  wire poison_nxt = fwd_nxt && wr_parity_err;                // [R01] [R07]
  wire perr_nxt   = np_drop || p_perr;                       // [R06] [R13]

  // Registered outputs; one-cycle pulses per event
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fwd_valid         <= 1'b0;
      fwd_poisoned      <= 1'b0;
      wr_discard        <= 1'b0;
      perr_assert       <= 1'b0;
      addr_target_abort <= 1'b0;
      rd_cpl_continue   <= 1'b0;
      msg_req           <= '0;
    end else begin
      fwd_valid         <= fwd_nxt;
      fwd_poisoned      <= poison_nxt;
      wr_discard        <= np_drop || aa_abort || attr_hit;  // [R16]
      perr_assert       <= perr_nxt;                         // [R06] [R13]
      addr_target_abort <= aa_abort || attr_hit;             // [R16] [R19]
      rd_cpl_continue   <= rd_cpl_perr;                      // [R14]
      msg_req.valid     <= any_msg;                          // [R10]
      msg_req.fatal     <= any_msg && msg_fatal;
    end
  end

  // ************************************************************
  // Delayed-transaction completion mapping
  // ************************************************************
  uef_cpl_map u_cpl_map (
    .sys_clk              (sys_clk),
    .rst                  (rst),
    .ir_master_abort_mode (ir_master_abort_mode),
    .cpl_evt              (cpl_evt),
    .dt_resp              (dt_resp)
  );
endmodule : uef_top

/* File: test/uef_top_chk.sv */
// Port-level assertions for the upstream error forwarding block
`timescale 1ns/100ps
module uef_top_chk (
  // Clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst,
  // Configuration and clears
  input wire logic                  secondary_parity_response_enable,
  input wire logic                  ir_master_abort_mode,
  input wire logic                  detected_parity_error_clr,
  // Events
  input wire logic                  wr_valid,
  input wire logic                  wr_posted,
  input wire logic                  wr_parity_err,
  input wire logic                  addr_parity_err,
  input wire logic                  attr_parity_err,
  input wire logic                  rd_cpl_perr,
  input wire logic                  rd_cpl_poisoned,
  input wire uef_pkg::uef_cpl_evt_t cpl_evt,
  // Decisions and status
  input wire logic                  fwd_valid,
  input wire logic                  fwd_poisoned,
  input wire logic                  wr_discard,
  input wire logic                  perr_assert,
  input wire logic                  addr_target_abort,
  input wire logic                  rd_cpl_continue,
  input wire uef_pkg::uef_dt_resp_t dt_resp,
  input wire uef_pkg::uef_msg_t     msg_req,
  input wire logic [3:0]            unc_status_r,
  input wire logic                  detected_parity_error_r,
  input wire logic                  signaled_system_error_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Bad data only; an address fault alongside overrides the write path
  sequence s_bad_wr;
    wr_valid && wr_parity_err && !addr_parity_err && !attr_parity_err;
  endsequence
  sequence s_ur_cpl;
    cpl_evt.valid && cpl_evt.status == uef_pkg::UEF_CPL_UR;
  endsequence
  a_np_drop_perr: assert property (
    s_bad_wr ##0 (!wr_posted && secondary_parity_response_enable)
    |=> perr_assert && wr_discard && !fwd_valid) else $error("bad write kept");
  a_poison_fwd: assert property (
    s_bad_wr ##0 !secondary_parity_response_enable
    |=> fwd_valid && fwd_poisoned && !perr_assert) else $error("no poison");
  a_ur_all_ones: assert property (
    s_ur_cpl ##0 (!ir_master_abort_mode && cpl_evt.kind != uef_pkg::UEF_DT_IOWR)
    |=> dt_resp.normal && dt_resp.data == 32'hFFFF_FFFF) else $error("no ones");
  a_ur_mode_abort: assert property (s_ur_cpl ##0 ir_master_abort_mode
    |=> dt_resp.target_abort && !dt_resp.normal) else $error("UR no abort");
  a_ca_abort: assert property (
    cpl_evt.valid && cpl_evt.status == uef_pkg::UEF_CPL_CA
    |=> dt_resp.valid && dt_resp.target_abort) else $error("CA no abort");
  a_rd_continue: assert property (rd_cpl_perr
    |=> rd_cpl_continue && unc_status_r[1]) else $error("read stopped");
  a_poison_quiet: assert property (
    rd_cpl_perr && rd_cpl_poisoned && !wr_valid && !addr_parity_err
    && !attr_parity_err |=> !msg_req.valid) else $error("poisoned msg");
  a_addr_abort: assert property (
    addr_parity_err && secondary_parity_response_enable
    |=> addr_target_abort && detected_parity_error_r) else $error("no abort");
  a_sys_err_cause: assert property (
    $rose(signaled_system_error_r) |-> msg_req.valid) else $error("sserr");
  a_dpe_sticky: assert property (
    $fell(detected_parity_error_r) |-> $past(detected_parity_error_clr))
    else $error("status lost");
endmodule : uef_top_chk

bind uef_top uef_top_chk i_uef_top_chk (.*);

/* File: test/uef_cpl_model.sv */
// Upstream completer model: answers a request after a set delay
`timescale 1ns/100ps
module uef_cpl_model (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Request from the bench
  input  wire logic                  req,
  input  wire uef_pkg::uef_dt_t      req_kind,
  input  wire uef_pkg::uef_cpl_t     req_status,
  input  wire logic [3:0]            req_dly,
  // Completion toward the bridge
  output uef_pkg::uef_cpl_evt_t      cpl_evt
);
  logic [3:0]            cnt_r;
  uef_pkg::uef_cpl_evt_t pend_r;
  // Hold one completion and release it when the delay runs out
  always_ff @(posedge sys_clk or posedge rst) begin
    cpl_evt <= '0;
    if (rst) begin
      pend_r <= '0;
      cnt_r <= 4'h0;
    end else if (req) begin
      pend_r <= '{1'b1, req_kind, req_status};
      cnt_r <= req_dly;
    end else if (pend_r.valid && cnt_r == 4'h0) begin
      cpl_evt <= pend_r;
      pend_r.valid <= 1'b0;
    end else begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : uef_cpl_model

/* File: test/tb.sv */
// Self-checking bench for the upstream error forwarding block
`timescale 1ns/100ps
module tb;
  logic sys_clk = 0, rst = 1, clr_all = 0, req = 0;
  logic secondary_parity_response_enable = 0, ir_master_abort_mode = 0;
  logic system_error_enable = 0, fatal_reporting_enable = 0;
  logic nonfatal_reporting_enable = 0;
  logic [3:0] err_mask = 4'h0, err_severity = 4'h0, req_dly = 4'h0;
  logic [6:0] ev_bus = 7'h00;
  logic [127:0] evt_header = '0, header_log_r;
  uef_pkg::uef_dt_t req_kind = uef_pkg::UEF_DT_MRD;
  uef_pkg::uef_cpl_t req_status = uef_pkg::UEF_CPL_SC;
  wire logic [3:0] unc_status_clr = {4{clr_all}};
  wire logic detected_parity_error_clr, master_data_parity_error_clr,
    signaled_target_abort_clr, signaled_system_error_clr,
    fatal_error_detected_clr, nonfatal_error_detected_clr,
    first_error_pointer_clr, wr_valid, wr_posted, wr_parity_err,
    addr_parity_err, attr_parity_err, rd_cpl_perr, rd_cpl_poisoned;
  uef_pkg::uef_cpl_evt_t cpl_evt;
  uef_pkg::uef_dt_resp_t dt_resp;
  uef_pkg::uef_msg_t msg_req;
  logic fwd_valid, fwd_poisoned, wr_discard, perr_assert, addr_target_abort,
    rd_cpl_continue, detected_parity_error_r, master_data_parity_error_r,
    signaled_target_abort_r, signaled_system_error_r,
    fatal_error_detected_r, nonfatal_error_detected_r;
  logic [3:0] unc_status_r;
  logic [2:0] first_error_pointer_r;
  int n_errors = 0, n_tests = 0;
  // One clear strobe feeds every software clear
  assign {detected_parity_error_clr, master_data_parity_error_clr,
    signaled_target_abort_clr, signaled_system_error_clr,
    fatal_error_detected_clr, nonfatal_error_detected_clr,
    first_error_pointer_clr} = {7{clr_all}};
  assign {wr_valid, wr_posted, wr_parity_err, addr_parity_err,
    attr_parity_err, rd_cpl_perr, rd_cpl_poisoned} = ev_bus;
  uef_top i_uef_top (.*);
  uef_cpl_model i_uef_cpl_model (.sys_clk(sys_clk), .rst(rst), .req(req),
    .req_kind(req_kind), .req_status(req_status), .req_dly(req_dly),
    .cpl_evt(cpl_evt));
  always #50 sys_clk = ~sys_clk;
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input string what, input logic [127:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  // Event pulse for one cycle; returns where the answer stands
  task automatic ev(input logic [6:0] e, input logic [127:0] h);
    ev_bus = e;
    evt_header = h;
    @(posedge sys_clk); #1;
    ev_bus = 7'h00;
  endtask : ev
  task automatic clr;
    clr_all = 1;
    @(posedge sys_clk); #1;
    clr_all = 0;
  endtask : clr
  task automatic t_write;
    secondary_parity_response_enable = 1;
    system_error_enable = 1;
    err_severity = 4'h1;
    ev(7'b1010000, 128'h1);
    check("drop", 3'b110, {perr_assert, wr_discard, fwd_valid});
    check("dpe", 1, detected_parity_error_r);
    check("udata", 1, unc_status_r[0]);
    check("ptr", 1, first_error_pointer_r);
    check("msg", 2'b11, msg_req);
    check("sserr", 1, signaled_system_error_r);
    check("fatal", 1, fatal_error_detected_r);
    ev(7'b1110000, 128'h2);
    check("mdpe", 2'b11, {perr_assert, master_data_parity_error_r});
    check("hdr", 128'h1, header_log_r);
    secondary_parity_response_enable = 0;
    ev(7'b1010000, 128'h3);
    check("poison", 3'b110, {fwd_valid, fwd_poisoned, perr_assert});
    ev(7'b1100000, 128'h4);
    check("sticky", 1, detected_parity_error_r);
    clr;
    check("cleared", 0, detected_parity_error_r);
    $display("test write parity done");
  endtask : t_write
  task automatic t_cpl;
    logic [1:0] k[5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h2};
    logic [1:0] s[5] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
    logic ta;
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 5; i++) begin
        ir_master_abort_mode = m[0];
        req_kind = uef_pkg::uef_dt_t'(k[i]);
        req_status = uef_pkg::uef_cpl_t'(s[i]);
        req_dly = 4'(i * 3);
        req = 1;
        @(posedge sys_clk); #1;
        req = 0;
        ta = m[0] || s[i] == 2'h2;
        for (int w = 0; w < 20 && dt_resp.valid !== 1'b1; w++) begin
          @(posedge sys_clk); #1;
        end
        check("resp", 1, dt_resp.valid);
        check("abort", {ta, !ta}, {dt_resp.target_abort, dt_resp.normal});
        check("ones", (!ta && k[i] != 2'h2) ? 33'h1_FFFF_FFFF : 33'h0,
          {dt_resp.force_ones, dt_resp.force_ones ? dt_resp.data : 32'h0});
      end
    end
    $display("test completion status done");
  endtask : t_cpl
  task automatic t_rdperr;
    err_severity = 4'h0;
    nonfatal_reporting_enable = 1;
    system_error_enable = 0;
    ev(7'b0000010, 128'h5);
    check("cont", 2'b11, {rd_cpl_continue, unc_status_r[1]});
    check("msg", 2'b10, msg_req);
    check("nonfatal", 1, nonfatal_error_detected_r);
    check("sserr", 0, signaled_system_error_r);
    check("ptr", 2, first_error_pointer_r);
    clr;
    ev(7'b0000011, 128'h6);
    check("quiet", 0, msg_req.valid);
    check("hdr", 128'h6, header_log_r);
    $display("test read completion done");
  endtask : t_rdperr
  task automatic t_addr;
    clr;
    secondary_parity_response_enable = 1;
    err_mask = 4'h8;
    ev(7'b0001000, 128'h7);
    check("abort", 2'b11, {addr_target_abort, signaled_target_abort_r});
    check("uaddr", 2'b11, {unc_status_r[2], msg_req.valid});
    check("ptr", 3, first_error_pointer_r);
    clr;
    ev(7'b0000100, 128'h8);
    check("uattr", 1, unc_status_r[3]);
    check("masked", 4'h0, {first_error_pointer_r, msg_req.valid});
    secondary_parity_response_enable = 0;
    clr;
    ev(7'b0001000, 128'h9);
    check("dpe", 2'b10, {detected_parity_error_r, addr_target_abort});
    $display("test address parity done");
  endtask : t_addr
  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // Tests need well under a thousand cycles; give them twenty thousand
  initial begin
    #(20000 * 100);
    n_errors++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 rst = 0;
    t_write;
    t_cpl;
    t_rdperr;
    t_addr;
    final_report;
  end
endmodule : tb
